//--- hw/general_register_file.v
// General registers, status longword and internal registers of the core.
`timescale 1ns/1ns
`include "gpr_map.vh"

// Contract
// - sixteen 32-bit registers, four-bit index
// - bits numbered zero upward from the right
// - index fifteen is the program counter
// - index fourteen is the stack pointer
// - index thirteen is the frame pointer
// - index twelve is the argument pointer
// - program counter refused as index register
// - byte, word, long sit in low bits
// - short writes keep the upper bits
// - short reads return only low bits
// - 64-bit datum spans registers n, n+1
// - pair wrap around counter is undefined
// - 128-bit datum spans n through n+3
// - quad wrap into counter is undefined
// - field start 0 to 31 over pair
// - no register layout for strings
// - status longword, privileged high, word low
// - status word holds codes and enables
// - procedure entry sets enables, clears float
// - separate privileged internal registers
// - bits 25:24 hold access level
// - trace pending set and faulted at start
module general_register_file #(
	parameter IPR_COUNT = 16,
	parameter IPR_AW    = 4
) (
	input  wire              sys_clk,
	input  wire              sys_rst,
	input  wire              wr_en,
	input  wire [3:0]        wr_index,
	input  wire [2:0]        wr_size,
	input  wire [127:0]      wr_data,
	input  wire              rd_en,
	input  wire [3:0]        rd_index,
	input  wire [2:0]        rd_size,
	output reg  [127:0]      rd_data_r,
	input  wire              ix_en,
	input  wire [3:0]        ix_index,
	output reg  [31:0]       ix_value_r,
	output reg               ix_fault_r,
	input  wire              bf_en,
	input  wire [3:0]        bf_index,
	input  wire [4:0]        bf_pos,
	input  wire [5:0]        bf_size,
	output reg  [31:0]       bf_data_r,
	input  wire              pc_inc_en,
	input  wire [3:0]        pc_inc,
	output wire [31:0]       instruction_address_counter,
	output wire [31:0]       stack_top_pointer,
	output wire [31:0]       frame_base_pointer,
	output wire [31:0]       argument_base_pointer,
	output reg               wrap_undef_r,
	input  wire              psl_wr_en,
	input  wire [31:0]       psl_wr_data,
	input  wire              psw_wr_en,
	input  wire [15:0]       psw_wr_data,
	input  wire              cc_wr_en,
	input  wire [3:0]        cc_in,
	input  wire              call_entry,
	input  wire              entry_iv,
	input  wire              entry_dv,
	input  wire              instr_start,
	output reg  [31:0]       processor_status_longword_r,
	output wire [1:0]        current_access_level,
	output reg               trace_fault_r,
	input  wire              ipr_wr_en,
	input  wire              ipr_rd_en,
	input  wire [IPR_AW-1:0] ipr_index,
	input  wire [31:0]       ipr_wr_data,
	output reg  [31:0]       ipr_rd_data_r
);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Number of consecutive registers that an operand of a size covers.
	function [2:0] reg_count;
		input [2:0] size;
		begin
			case (size)
				`SZ_BYTE: reg_count = 3'h1;
				`SZ_WORD: reg_count = 3'h1;
				`SZ_LONG: reg_count = 3'h1;
				`SZ_QUAD: reg_count = 3'h2;
				`SZ_OCTA: reg_count = 3'h4;
				default:  reg_count = 3'h0;
			endcase
		end
	endfunction

	// Bits of the first register that an operand of a size covers.
	function [31:0] low_mask;
		input [2:0] size;
		begin
			case (size)
				`SZ_BYTE: low_mask = `MASK_BYTE;
				`SZ_WORD: low_mask = `MASK_WORD;
				default:  low_mask = `MASK_LONG;
			endcase
		end
	endfunction

	// An operand whose span wraps past or runs into the counter.
	function span_undefined;
		input [3:0] index;
		input [2:0] size;
		begin
			case (size)
				`SZ_QUAD: span_undefined = (index >= `IDX_SP);
				`SZ_OCTA: span_undefined = (index >= `IDX_AP);
				default:  span_undefined = 1'b0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------

	reg [31:0] general_register_r [0:15];
	reg [31:0] ipr_r [0:IPR_COUNT-1];
	reg [31:0] psl_nxt;
	reg [127:0] rd_data_nxt;
	reg [3:0]  wr_offs;
	reg [3:0]  rd_slot;
	reg [3:0]  i4;
	reg [2:0]  wr_n;
	reg [2:0]  rd_n;
	reg [31:0] wr_mask;
	reg [31:0] rd_mask;
	reg [31:0] pc_nxt;
	reg [31:0] gpr_nxt [0:15];
	wire       wr_ok;
	wire [3:0] bf_next_index;
	wire [31:0] bf_field;
	integer    i;
	integer    j;
	integer    k;
	integer    m;

	assign instruction_address_counter = general_register_r[`IDX_PC];
	assign stack_top_pointer = general_register_r[`IDX_SP];
	assign frame_base_pointer = general_register_r[`IDX_FP];
	assign argument_base_pointer = general_register_r[`IDX_AP];
	assign current_access_level =
		processor_status_longword_r[`PSL_MODE_HI:`PSL_MODE_LO];

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------

	// drop wrapping writes
	// A wrapping write is undefined; dropping it whole keeps every
	// register consistent instead of half-updating the counter.
	assign wr_ok = wr_en && !span_undefined(wr_index, wr_size);

	// Counter advance applies only when no write lands on the counter.
	always @* begin
		pc_nxt = general_register_r[`IDX_PC] + {28'h0000000, pc_inc};
	end

	// bit zero rightmost
	// Next value of every register, worked out before the edge.
	always @* begin
		i4 = 4'h0;
		wr_offs = 4'h0;
		wr_mask = `MASK_LONG;
		wr_n = reg_count(wr_size);
		for (i = 0; i < 16; i = i + 1) begin
			i4 = i[3:0];
			wr_offs = i4 - wr_index;
			wr_mask = (wr_offs == 4'h0) ? low_mask(wr_size)
				: `MASK_LONG;
			gpr_nxt[i] = general_register_r[i];
			if (wr_ok && ({1'b0, wr_offs} < {2'b00, wr_n}))
				gpr_nxt[i] = (general_register_r[i] & ~wr_mask) |
					(wr_data[wr_offs*32 +: 32] & wr_mask);
			else if (pc_inc_en && (i4 == `IDX_PC))
				gpr_nxt[i] = pc_nxt;
		end
	end

	// one-cycle commit
	// All registers covered by one write update on the same edge.
	always @(posedge sys_clk) begin
		for (j = 0; j < 16; j = j + 1)
			general_register_r[j] <= sys_rst ? `GPR_RESET : gpr_nxt[j];
	end

	// ------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------

	// low-bit placement
	// Slices are gathered in ascending register order; a short operand
	// leaves every bit above it at zero.
	always @* begin
		rd_data_nxt = 128'h0;
		rd_slot = 4'h0;
		rd_mask = `MASK_LONG;
		rd_n = reg_count(rd_size);
		for (k = 0; k < 4; k = k + 1) begin
			rd_slot = rd_index + k[3:0];
			rd_mask = (k == 0) ? low_mask(rd_size) : `MASK_LONG;
			if (k < rd_n)
				rd_data_nxt[k*32 +: 32] =
					general_register_r[rd_slot] & rd_mask;
		end
	end

	// Read data stand only in the cycle after the strobe.
	always @(posedge sys_clk) begin
		if (sys_rst)
			rd_data_r <= 128'h0;
		else if (rd_en)
			rd_data_r <= rd_data_nxt;
		else
			rd_data_r <= 128'h0;
	end

	// ------------------------------------------------------------------
	// Index operand port and wrap report
	// ------------------------------------------------------------------

	// counter not an index
	// Other dedicated registers stay usable; only the counter faults.
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ix_value_r <= 32'h0;
			ix_fault_r <= 1'b0;
		end else begin
			ix_fault_r <= ix_en && (ix_index == `IDX_PC);
			if (ix_en && (ix_index != `IDX_PC))
				ix_value_r <= general_register_r[ix_index];
			else
				ix_value_r <= 32'h0;
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst)
			wrap_undef_r <= 1'b0;
		else
			wrap_undef_r <=
				(wr_en && span_undefined(wr_index, wr_size)) ||
				(rd_en && span_undefined(rd_index, rd_size));
	end

	// ------------------------------------------------------------------
	// Bit field port
	// ------------------------------------------------------------------

	// pair as one value
	// A field whose pair wraps past the counter reads index zero high.
	assign bf_next_index = bf_index + 4'h1;

	bitfield_extract #(
		.W(32)
	) u_bitfield (
		.pair  ({general_register_r[bf_next_index],
			general_register_r[bf_index]}),
		.pos   (bf_pos),
		.size  (bf_size),
		.field (bf_field)
	);

	always @(posedge sys_clk) begin
		if (sys_rst)
			bf_data_r <= 32'h0;
		else if (bf_en)
			bf_data_r <= bf_field;
		else
			bf_data_r <= 32'h0;
	end

	// strings never come from the registers, so no port here.

	// ------------------------------------------------------------------
	// Status longword
	// ------------------------------------------------------------------

	// codes and enables
	// A full write wins over a word write, which wins over the events.
	// Reserved and unimplemented bits are forced to zero on every path.
	always @* begin
		psl_nxt = processor_status_longword_r;
		if (psl_wr_en) begin
			psl_nxt = psl_wr_data;
		end else if (psw_wr_en) begin
			psl_nxt = (processor_status_longword_r & ~`PSW_MASK) |
				{16'h0000, psw_wr_data};
		end else begin
			if (cc_wr_en)
				psl_nxt = (psl_nxt & ~`PSW_CC_MASK) |
					{28'h0000000, cc_in};
			if (call_entry) begin
				psl_nxt[`PSL_IV] = entry_iv;
				psl_nxt[`PSL_DV] = entry_dv;
				psl_nxt[`PSL_FU] = 1'b0;
			end
			if (instr_start)
				psl_nxt[`PSL_TP] =
					processor_status_longword_r[`PSL_TRACE];
		end
		psl_nxt = psl_nxt & `PSL_WR_MASK;
	end

	always @(posedge sys_clk) begin
		if (sys_rst)
			processor_status_longword_r <= `PSL_RESET;
		else
			processor_status_longword_r <= psl_nxt;
	end

	// trace fault at start
	// The fault looks at the pending bit as it stood before this start.
	always @(posedge sys_clk) begin
		if (sys_rst)
			trace_fault_r <= 1'b0;
		else
			trace_fault_r <= instr_start &&
				processor_status_longword_r[`PSL_TP];
	end

	// ------------------------------------------------------------------
	// Privileged internal registers
	// ------------------------------------------------------------------

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			for (m = 0; m < IPR_COUNT; m = m + 1)
				ipr_r[m] <= `IPR_RESET;
		end else if (ipr_wr_en && (ipr_index < IPR_COUNT)) begin
			ipr_r[ipr_index] <= ipr_wr_data;
		end
	end

	// Out-of-range indices read as zero.
	always @(posedge sys_clk) begin
		if (sys_rst)
			ipr_rd_data_r <= 32'h0;
		else if (ipr_rd_en && (ipr_index < IPR_COUNT))
			ipr_rd_data_r <= ipr_r[ipr_index];
		else
			ipr_rd_data_r <= 32'h0;
	end

endmodule

//--- pkg/gpr_map.vh
// Constants for the general register file: sizes, indices and status fields.
`ifndef GPR_MAP_VH
`define GPR_MAP_VH

// ----------------------------------------------------------------------
// Operand size codes
// ----------------------------------------------------------------------
`define SZ_BYTE      3'h0
`define SZ_WORD      3'h1
`define SZ_LONG      3'h2
`define SZ_QUAD      3'h3
`define SZ_OCTA      3'h4

// ----------------------------------------------------------------------
// Dedicated register indices
// ----------------------------------------------------------------------
`define IDX_AP       4'hc
`define IDX_FP       4'hd
`define IDX_SP       4'he
`define IDX_PC       4'hf

// ----------------------------------------------------------------------
// Data layout
// ----------------------------------------------------------------------
`define MASK_BYTE    32'h000000ff
`define MASK_WORD    32'h0000ffff
`define MASK_LONG    32'hffffffff
`define GPR_RESET    32'h00000000
`define BF_SIZE_MAX  6'h20

// ----------------------------------------------------------------------
// Status longword fields
// ----------------------------------------------------------------------
`define PSL_RESET    32'h00000000
`define PSL_WR_MASK  32'h4fdf00ff
`define PSW_MASK     32'h0000ffff
`define PSW_CC_MASK  32'h0000000f
`define PSL_TRACE    4
`define PSL_IV       5
`define PSL_FU       6
`define PSL_DV       7
`define PSL_TP       30
`define PSL_MODE_LO  24
`define PSL_MODE_HI  25
`define IPR_RESET    32'h00000000

`endif

//--- hw/bitfield_extract.v
// Bit field extractor over a 64-bit register pair.
`timescale 1ns/1ns
`include "gpr_map.vh"

module bitfield_extract #(
	parameter W = 32
) (
	input  wire [2*W-1:0] pair,
	input  wire [4:0]     pos,
	input  wire [5:0]     size,
	output reg  [W-1:0]   field
);

	// ------------------------------------------------------------------
	// Extraction
	// ------------------------------------------------------------------

	reg [2*W-1:0] shifted;
	reg [W-1:0]   mask;

	// Shift the pair right by the start bit, then keep size bits.
	// The 5-bit start position cannot leave the 0 to 31 range.
	always @* begin
		shifted = pair >> pos;
		if (size >= `BF_SIZE_MAX)
			mask = {W{1'b1}};
		else
			mask = ~({W{1'b1}} << size);
		field = shifted[W-1:0] & mask;
	end

endmodule

//--- dv/gpr_sva.sv
// Port assertions for the general register file.
`timescale 1ns/1ns
`include "gpr_map.vh"
module gpr_sva (
	input wire         sys_clk,
	input wire         sys_rst,
	input wire         wr_en,
	input wire [3:0]   wr_index,
	input wire [2:0]   wr_size,
	input wire [127:0] wr_data,
	input wire         rd_en,
	input wire [2:0]   rd_size,
	input wire [127:0] rd_data_r,
	input wire         ix_en,
	input wire [3:0]   ix_index,
	input wire [31:0]  ix_value_r,
	input wire         ix_fault_r,
	input wire [31:0]  instruction_address_counter,
	input wire         wrap_undef_r,
	input wire         call_entry,
	input wire         entry_iv,
	input wire         entry_dv,
	input wire         instr_start,
	input wire         psl_wr_en,
	input wire         psw_wr_en,
	input wire [31:0]  processor_status_longword_r,
	input wire [1:0]   current_access_level,
	input wire         trace_fault_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	ix_refuse_a: assert property (
		ix_en && ix_index == `IDX_PC |=> ix_fault_r && ix_value_r == 32'h0)
		else $error("counter accepted as index");
	rd_idle_a: assert property (
		!rd_en |=> rd_data_r == 128'h0) else $error("read data not idle");
	rd_short_a: assert property (
		rd_en && rd_size <= `SZ_WORD |=>
		(rd_data_r >> ($past(rd_size) == `SZ_WORD ? 16 : 8)) == 128'h0)
		else $error("short read leaks upper bits");
	quad_wrap_a: assert property (
		wr_en && wr_size == `SZ_QUAD && wr_index[3:1] == 3'h7
		|=> wrap_undef_r) else $error("pair wrap not flagged");
	octa_wrap_a: assert property (
		wr_en && wr_size == `SZ_OCTA && wr_index[3:2] == 2'h3
		|=> wrap_undef_r) else $error("quad wrap not flagged");
	counter_write_a: assert property (
		wr_en && wr_size == `SZ_LONG && wr_index == `IDX_PC |=>
		{96'h0, instruction_address_counter} == ($past(wr_data) &
		128'hffffffff)) else $error("counter write lost");
	status_resv_a: assert property (
		(processor_status_longword_r & ~`PSL_WR_MASK) == 32'h0)
		else $error("reserved status bits set");
	level_map_a: assert property (
		current_access_level == processor_status_longword_r[25:24])
		else $error("access level mismatch");
	trace_a: assert property (
		instr_start |=> trace_fault_r ==
		$past(processor_status_longword_r[30]))
		else $error("trace fault mismatch");
	entry_a: assert property (
		call_entry && !psl_wr_en && !psw_wr_en |=>
		processor_status_longword_r[7:5] ==
		{$past(entry_dv), 1'b0, $past(entry_iv)} &&
		$stable(processor_status_longword_r[4]))
		else $error("entry enables wrong");
endmodule

bind general_register_file gpr_sva u_sva (.sys_clk, .sys_rst, .wr_en,
	.wr_index, .wr_size, .wr_data, .rd_en, .rd_size, .rd_data_r, .ix_en,
	.ix_index, .ix_value_r, .ix_fault_r, .instruction_address_counter,
	.wrap_undef_r, .call_entry, .entry_iv, .entry_dv, .instr_start,
	.psl_wr_en, .psw_wr_en, .processor_status_longword_r,
	.current_access_level, .trace_fault_r);

//--- dv/exec_model.sv
// Execution datapath model issuing register transfers.
`timescale 1ns/1ns
module exec_model (
	input  wire          sys_clk,
	output logic         wr_en = 1'b0,
	output logic [3:0]   wr_index = 4'h0,
	output logic [2:0]   wr_size = 3'h0,
	output logic [127:0] wr_data = 128'h0,
	output logic         rd_en = 1'b0,
	output logic [3:0]   rd_index = 4'h0,
	output logic [2:0]   rd_size = 3'h0,
	output logic         bf_en = 1'b0,
	output logic [3:0]   bf_index = 4'h0,
	output logic [4:0]   bf_pos = 5'h0,
	output logic [5:0]   bf_size = 6'h0
);
	// Released write data and read index show the inverse so stale data never passes.
	task automatic wr(input logic [3:0] i, input logic [2:0] s,
		input logic [127:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		wr_index <= i;
		wr_size <= s;
		wr_data <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		wr_data <= ~d;
	endtask

	task automatic rd(input logic [3:0] i, input logic [2:0] s);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		rd_index <= i;
		rd_size <= s;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		rd_index <= ~i;
	endtask

	task automatic bf(input logic [3:0] i, input logic [4:0] p,
		input logic [5:0] n);
		@(posedge sys_clk);
		bf_en <= 1'b1;
		bf_index <= i;
		bf_pos <= p;
		bf_size <= n;
		@(posedge sys_clk);
		bf_en <= 1'b0;
	endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for the general register file.
`timescale 1ns/1ns
`include "gpr_map.vh"
module tb;
	logic         sys_clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         pc_inc_en = 1'b0, ix_en = 1'b0, psl_wr_en = 1'b0;
	logic         call_entry = 1'b0, entry_iv = 1'b0, entry_dv = 1'b0;
	logic         instr_start = 1'b0, ipr_wr_en = 1'b0, ipr_rd_en = 1'b0;
	logic [3:0]   pc_inc = 4'h0, ix_index = 4'h0, ipr_index = 4'h0;
	logic [31:0]  psl_wr_data = 32'h0, ipr_wr_data = 32'h0;
	logic         psw_wr_en = 1'b0, cc_wr_en = 1'b0;
	logic [15:0]  psw_wr_data = 16'h0;
	logic [3:0]   cc_in = 4'h0;
	wire          wr_en, rd_en, bf_en, ix_fault_r, wrap_undef_r;
	wire          trace_fault_r;
	wire [3:0]    wr_index, rd_index, bf_index;
	wire [2:0]    wr_size, rd_size;
	wire [4:0]    bf_pos;
	wire [5:0]    bf_size;
	wire [1:0]    current_access_level;
	wire [127:0]  wr_data, rd_data_r;
	wire [31:0]   ix_value_r, bf_data_r, instruction_address_counter;
	wire [31:0]   stack_top_pointer, frame_base_pointer, ipr_rd_data_r;
	wire [31:0]   argument_base_pointer, processor_status_longword_r;
	int           error_cnt = 0;
	int           samples_checked = 0;
	localparam logic [127:0] OCT = 128'hfedcba98_76543210_0f1e2d3c_4b5a6978;

	exec_model u_dp (.sys_clk, .wr_en, .wr_index, .wr_size, .wr_data,
		.rd_en, .rd_index, .rd_size, .bf_en, .bf_index, .bf_pos, .bf_size);
	general_register_file u_dut (.sys_clk, .sys_rst, .wr_en, .wr_index,
		.wr_size, .wr_data, .rd_en, .rd_index, .rd_size, .rd_data_r,
		.ix_en, .ix_index, .ix_value_r, .ix_fault_r, .bf_en, .bf_index,
		.bf_pos, .bf_size, .bf_data_r, .pc_inc_en, .pc_inc,
		.instruction_address_counter, .stack_top_pointer,
		.frame_base_pointer, .argument_base_pointer, .wrap_undef_r,
		.psl_wr_en, .psl_wr_data, .psw_wr_en, .psw_wr_data,
		.cc_wr_en, .cc_in, .call_entry, .entry_iv, .entry_dv,
		.instr_start, .processor_status_longword_r, .current_access_level,
		.trace_fault_r, .ipr_wr_en, .ipr_rd_en, .ipr_index, .ipr_wr_data,
		.ipr_rd_data_r);

	// 100 MHz clock.
	always #5 sys_clk = ~sys_clk;

	task automatic chk(input string n, input logic [127:0] e,
		input logic [127:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic rd_chk(input string n, input logic [3:0] i,
		input logic [2:0] s, input logic [127:0] e);
		u_dp.rd(i, s);
		#1;
		chk(n, e, rd_data_r);
	endtask

	task automatic t_layout;
		u_dp.wr(4'h0, `SZ_OCTA, OCT);
		rd_chk("slice0", 4'h0, `SZ_LONG, OCT & 128'hffffffff);
		rd_chk("pair_hi", 4'h2, `SZ_QUAD, OCT >> 64);
		rd_chk("slice3", 4'h3, `SZ_LONG, OCT >> 96);
		u_dp.wr(4'h5, `SZ_LONG, 128'h89abcdef);
		u_dp.wr(4'h5, `SZ_BYTE, ~128'hee);
		rd_chk("byte_wr", 4'h5, `SZ_LONG, 128'h89abcd11);
		u_dp.wr(4'h5, `SZ_WORD, ~128'hddcc);
		rd_chk("word_wr", 4'h5, `SZ_LONG, 128'h89ab2233);
		rd_chk("byte_rd", 4'h5, `SZ_BYTE, 128'h33);
		rd_chk("word_rd", 4'h5, `SZ_WORD, 128'h2233);
	endtask

	task automatic t_dedicated;
		for (int i = 12; i < 16; i++)
			u_dp.wr(4'(i), `SZ_LONG, 128'(32'h100 * i));
		#1;
		chk("args", 32'hc00, argument_base_pointer);
		chk("frame", 32'hd00, frame_base_pointer);
		chk("stack", 32'he00, stack_top_pointer);
		chk("counter", 32'hf00, instruction_address_counter);
		@(posedge sys_clk);
		ix_en <= 1'b1;
		ix_index <= `IDX_SP;
		@(posedge sys_clk);
		ix_index <= `IDX_PC;
		pc_inc_en <= 1'b1;
		pc_inc <= 4'h4;
		#1;
		chk("ix_val", 32'he00, ix_value_r);
		@(posedge sys_clk);
		ix_en <= 1'b0;
		pc_inc_en <= 1'b0;
		#1;
		chk("ix_fault", 1'b1, ix_fault_r);
		chk("ix_zero", 32'h0, ix_value_r);
		chk("advance", 32'hf04, instruction_address_counter);
	endtask

	task automatic t_wrap;
		u_dp.wr(`IDX_SP, `SZ_QUAD, ~128'h0);
		#1;
		chk("wrap2", 1'b1, wrap_undef_r);
		chk("stack_kept", 32'he00, stack_top_pointer);
		u_dp.wr(`IDX_FP, `SZ_OCTA, ~128'h0);
		#1;
		chk("wrap4", 1'b1, wrap_undef_r);
		chk("frame_kept", 32'hd00, frame_base_pointer);
		u_dp.wr(4'h6, `SZ_QUAD, 128'ha5c30f96_12345678);
		u_dp.bf(4'h6, 5'd28, 6'd8);
		#1;
		chk("field", 32'h61, bf_data_r);
		u_dp.bf(4'h6, 5'd31, 6'h20);
		#1;
		chk("field_edge", 32'h4b861f2c, bf_data_r);
	endtask

	task automatic t_status;
		@(posedge sys_clk);
		psl_wr_en <= 1'b1;
		psl_wr_data <= 32'hffffffff;
		ipr_wr_en <= 1'b1;
		ipr_index <= 4'h3;
		ipr_wr_data <= 32'h5a5a0001;
		@(posedge sys_clk);
		psl_wr_en <= 1'b0;
		ipr_wr_en <= 1'b0;
		ipr_rd_en <= 1'b1;
		instr_start <= 1'b1;
		#1;
		chk("status", 32'h4fdf00ff, processor_status_longword_r);
		chk("level", 2'h3, current_access_level);
		@(posedge sys_clk);
		ipr_rd_en <= 1'b0;
		instr_start <= 1'b0;
		call_entry <= 1'b1;
		entry_dv <= 1'b1;
		#1;
		chk("trace", 1'b1, trace_fault_r);
		chk("internal", 32'h5a5a0001, ipr_rd_data_r);
		@(posedge sys_clk);
		call_entry <= 1'b0;
		#1;
		chk("entry", 32'h4fdf009f, processor_status_longword_r);
		@(posedge sys_clk);
		cc_wr_en <= 1'b1;
		cc_in <= 4'h5;
		@(posedge sys_clk);
		cc_wr_en <= 1'b0;
		psw_wr_en <= 1'b1;
		psw_wr_data <= 16'h1234;
		#1;
		chk("codes", 32'h4fdf0095, processor_status_longword_r);
		@(posedge sys_clk);
		psw_wr_en <= 1'b0;
		#1;
		chk("word", 32'h4fdf0034, processor_status_longword_r);
	endtask

	task automatic summarize;
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence: reset, then each scenario in turn.
	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		chk("rst_counter", 32'h0, instruction_address_counter);
		t_layout();
		t_dedicated();
		t_wrap();
		t_status();
		summarize();
	end

	// Watchdog: the run needs well under a thousand cycles.
	initial begin
		#20000;
		error_cnt++;
		summarize();
	end
endmodule
